/* File: verilog/tldm_map.svh */
// Constants for the ternary line decode monitor
`ifndef TLDM_MAP_SVH
`define TLDM_MAP_SVH
`define TLDM_SYMS_PER_GROUP 2'd3
`define TLDM_SUM_RESET 4'sd1
`define TLDM_SUM_MIN 4'sd1
`define TLDM_SUM_MAX 4'sd4
`define TLDM_SUM_LOW 4'sd0
`define TLDM_ERR_MAX 8'hFF
`define TLDM_SCR_TAP 5'd18
`define TLDM_DSC_TAP 5'd5
`define TLDM_CMD_TIM 4'h0
`define TLDM_CMD_LTD 4'h3
`define TLDM_CMD_SSP 4'h5
`define TLDM_CMD_DT 4'h6
`define TLDM_CMD_AR 4'h8
`define TLDM_CMD_RSV 4'h9
`define TLDM_CMD_AI 4'hC
`define TLDM_CMD_RES 4'hD
`define TLDM_CMD_DI 4'hF
`define TLDM_IND_DR 4'h0
`define TLDM_IND_RSY 4'h4
`define TLDM_IND_AR 4'h8
`define TLDM_IND_ARL 4'hA
`define TLDM_IND_AI 4'hC
`define TLDM_IND_AIL 4'hE
`define TLDM_IND_DC 4'hF
`define TLDM_SYM_ZERO 2'b00
`define TLDM_SYM_POS 2'b01
`define TLDM_SYM_NEG 2'b11
`endif

/* File: verilog/tldm_pkg.sv */
// Types for the ternary line decode monitor
package tldm_pkg;
   typedef logic [1:0] tldm_sym_t;
   typedef logic [3:0] tldm_nibble_t;
   typedef enum logic [3:0] {
      LINK_DEACTIVATED,
      LINK_SYNCHRONIZING,
      LINK_WAIT_INFO,
      LINK_FOUR_HIGH,
      LINK_TRANSPARENT,
      LINK_OTHER
   } tldm_link_state_t;
   typedef struct packed {
      logic valid;
      logic [3:0] data;
      logic violation;
   } tldm_rx_word_t;
endpackage

/* File: verilog/tldm_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module tldm_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("tldm_fifo: DEPTH must be a power of two, at least 2");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wrPtr;
      logic [AW:0] rdPtr;
   } tldm_fifo_state_t;
   tldm_fifo_state_t state_reg;
   tldm_fifo_state_t state_next;
   logic full;
   logic empty;
   assign full = (state_reg.wrPtr[AW] != state_reg.rdPtr[AW])
      && (state_reg.wrPtr[AW-1:0] == state_reg.rdPtr[AW-1:0]);
   assign empty = state_reg.wrPtr == state_reg.rdPtr;
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = state_reg.mem[state_reg.rdPtr[AW-1:0]];
   always_comb
   begin
      state_next = state_reg;
      if (inValid && !full)
      begin
         state_next.mem[state_reg.wrPtr[AW-1:0]] = inData;
         state_next.wrPtr = state_reg.wrPtr + 1'b1;
      end
      if (outReady && !empty)
         state_next.rdPtr = state_reg.rdPtr + 1'b1;
   end
   always_ff @(posedge clock)
   begin
      if (reset)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end
endmodule // tldm_fifo

/* File: verilog/tldm_line_decode.sv */
// Ternary receive decode, sum monitor, error counter, scramblers and command check
// How it works
// - Three received symbols become one nibble; first symbol and first bit leftmost.
// - An all-zero symbol group decodes to nibble 0000.
// - Fixed table maps the printed ternary groups to their nibbles.
// - Running sum adds +1, 0 or -1 per received symbol.
// - Violation when group-end sum below one, above four, or group all zero.
// - Frame with a violation counts one error; the frame after next sends positive maintenance symbol.
// - Reading the error count returns it and clears the counter.
// - Counter runs only in sync, wait-info, four-high, transparent; cleared otherwise.
// - Counter saturates at its maximum and holds.
// - Transmit bits scrambled with z^-23 + z^-18 + 1.
// - Decoded bits feed a z^-23 + z^-5 + 1 self-aligning descrambler whose bit dscBit reaches no output.
// - Scrambling is fixed, with no control inputs.
// - Changed command accepted only after two equal consecutive frames.
// - Input command codes decoded to named strobes; 1001 reserved.
// - Outgoing indication restricted to the defined code set.
// - Activation state supplied externally; counter follows only listed states.
`timescale 1ns/1ps
`include "tldm_map.svh"
module tldm_line_decode #(
   parameter int FIFO_DEPTH = 8,
   parameter int COUNT_WIDTH = 8
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic rxSymValid,
   input wire logic [1:0] rxSym,
   input wire logic rxFrameEnd,
   input wire logic rxOutReady,
   output logic rxOutValid,
   output logic [3:0] rxOutData,
   output logic rxSymReady,
   output logic codeViolation,
   output logic maintPositive,
   input wire tldm_pkg::tldm_link_state_t linkState,
   input wire logic errCountRead,
   output logic [COUNT_WIDTH-1:0] errCount,
   input wire logic txBitValid,
   input wire logic txBitIn,
   output logic txBitOut,
   output logic txBitOutValid,
   input wire logic hostFrameStrobe,
   input wire logic [3:0] cmdIn,
   output logic [3:0] cmdValid,
   output logic cmdChanged,
   output logic cmdTimingReq,
   output logic cmdFarDisable,
   output logic cmdSinglePulse,
   output logic cmdDataThrough,
   output logic cmdActivationReq,
   output logic cmdLayer1Up,
   output logic cmdReset,
   output logic cmdPowerDownAllowed,
   input wire logic [3:0] indIn,
   output logic [3:0] indOut
);
   initial
   begin
      if (COUNT_WIDTH != 8)
         $error("tldm_line_decode: COUNT_WIDTH must be 8");
   end

   typedef struct packed {
      logic [1:0] symIdx;
      logic [5:0] group;
      logic signed [3:0] runSum;
      logic frameErr;
      logic maintPending;
      logic maint;
      logic [7:0] errCnt;
      logic [22:0] scr;
      logic [22:0] dsc;
      logic [3:0] nibSr;
      logic [2:0] nibCnt;
      logic [3:0] decNib;
      logic decViol;
      logic decValid;
      logic txOut;
      logic txOutValid;
      logic [3:0] cmdLast;
      logic [3:0] cmdOk;
      logic changed;
      logic [3:0] ind;
   } tldm_state_t;

   tldm_state_t state_reg;
   tldm_state_t state_next;
   logic fifoInReady;

   function automatic logic signed [3:0] symWeight(input logic [1:0] s);
      case (s)
         `TLDM_SYM_POS: symWeight = 4'sd1;
         `TLDM_SYM_NEG: symWeight = -4'sd1;
         default: symWeight = 4'sd0;
      endcase
   endfunction

   // Symbol encoding: 0 -> 0, + -> 1, - -> 2 as base-3 digit
   function automatic logic [1:0] tdig(input logic [1:0] s);
      case (s)
         `TLDM_SYM_POS: tdig = 2'd1;
         `TLDM_SYM_NEG: tdig = 2'd2;
         default: tdig = 2'd0;
      endcase
   endfunction

   function automatic logic [3:0] decodeGroup(input logic [5:0] g);
      logic [5:0] k;
      k = {tdig(g[5:4]), tdig(g[3:2]), tdig(g[1:0])};
      case (k)
         {2'd0, 2'd0, 2'd0}, {2'd1, 2'd0, 2'd1}, {2'd0, 2'd2, 2'd0}: decodeGroup = 4'h0;
         {2'd0, 2'd2, 2'd1}: decodeGroup = 4'h1;
         {2'd1, 2'd2, 2'd0}: decodeGroup = 4'h2;
         {2'd0, 2'd0, 2'd1}, {2'd2, 2'd2, 2'd0}: decodeGroup = 4'h3;
         {2'd2, 2'd1, 2'd0}: decodeGroup = 4'h4;
         {2'd0, 2'd1, 2'd1}, {2'd2, 2'd0, 2'd0}: decodeGroup = 4'h5;
         {2'd2, 2'd1, 2'd1}, {2'd2, 2'd2, 2'd1}: decodeGroup = 4'h6;
         {2'd2, 2'd0, 2'd1}: decodeGroup = 4'h7;
         {2'd1, 2'd0, 2'd0}, {2'd0, 2'd2, 2'd2}: decodeGroup = 4'h8;
         {2'd1, 2'd2, 2'd1}, {2'd2, 2'd2, 2'd2}: decodeGroup = 4'h9;
         {2'd1, 2'd1, 2'd2}, {2'd1, 2'd2, 2'd2}: decodeGroup = 4'hA;
         {2'd1, 2'd0, 2'd2}: decodeGroup = 4'hB;
         {2'd1, 2'd1, 2'd1}, {2'd2, 2'd1, 2'd2}: decodeGroup = 4'hC;
         {2'd0, 2'd1, 2'd0}, {2'd2, 2'd0, 2'd2}: decodeGroup = 4'hD;
         {2'd0, 2'd1, 2'd2}: decodeGroup = 4'hE;
         {2'd1, 2'd1, 2'd0}, {2'd0, 2'd0, 2'd2}: decodeGroup = 4'hF;
         default: decodeGroup = 4'h0;
      endcase
   endfunction

   function automatic logic countingState(input tldm_pkg::tldm_link_state_t s);
      case (s)
         tldm_pkg::LINK_SYNCHRONIZING, tldm_pkg::LINK_WAIT_INFO,
         tldm_pkg::LINK_FOUR_HIGH, tldm_pkg::LINK_TRANSPARENT: countingState = 1'b1;
         default: countingState = 1'b0;
      endcase
   endfunction

   function automatic logic legalInd(input logic [3:0] c);
      case (c)
         `TLDM_IND_DR, `TLDM_IND_RSY, `TLDM_IND_AR, `TLDM_IND_ARL,
         `TLDM_IND_AI, `TLDM_IND_AIL, `TLDM_IND_DC: legalInd = 1'b1;
         default: legalInd = 1'b0;
      endcase
   endfunction

   logic [5:0] groupFull;
   logic signed [3:0] sumStart;
   logic signed [3:0] sumEnd;
   logic groupDone;
   logic violNow;
   logic dscBit;

   assign rxSymReady = fifoInReady;
   assign groupFull = {state_reg.group[3:0], rxSym};
   assign groupDone = rxSymValid && fifoInReady && (state_reg.symIdx == `TLDM_SYMS_PER_GROUP - 2'd1);

   always_comb
   begin
      // Clamp happens as the next group begins
      sumStart = state_reg.runSum;
      if (state_reg.symIdx == 2'd0)
      begin
         if (state_reg.runSum > 4'(`TLDM_SUM_MAX))
            sumStart = 4'(`TLDM_SUM_MAX);
         else if (state_reg.runSum <= 4'(`TLDM_SUM_LOW))
            sumStart = 4'(`TLDM_SUM_MIN);
      end
      sumEnd = sumStart + symWeight(rxSym);
      violNow = groupDone && ((sumEnd < 4'(`TLDM_SUM_MIN)) || (sumEnd > 4'(`TLDM_SUM_MAX))
         || (groupFull == 6'h00));
   end

   always_comb
   begin
      dscBit = 1'b0;
      state_next = state_reg;
      state_next.decValid = 1'b0;
      state_next.txOutValid = 1'b0;
      state_next.changed = 1'b0;
      if (rxSymValid && fifoInReady)
      begin
         state_next.group = groupFull;
         state_next.runSum = sumEnd;
         state_next.symIdx = groupDone ? 2'd0 : state_reg.symIdx + 2'd1;
      end
      if (groupDone)
      begin
         state_next.decNib = decodeGroup(groupFull);
         state_next.decViol = violNow;
         state_next.decValid = 1'b1;
         state_next.nibSr = decodeGroup(groupFull);
         state_next.nibCnt = 3'd4;
         if (violNow)
            state_next.frameErr = 1'b1;
      end
      else if (state_reg.nibCnt != 3'd0)
      begin
         // Descramble one decoded bit per cycle, leftmost first
         dscBit = state_reg.nibSr[3] ^ state_reg.dsc[`TLDM_DSC_TAP - 5'd1]
            ^ state_reg.dsc[22];
         state_next.dsc = {state_reg.dsc[21:0], state_reg.nibSr[3]};
         state_next.nibSr = {state_reg.nibSr[2:0], 1'b0};
         state_next.nibCnt = state_reg.nibCnt - 3'd1;
      end
      if (rxFrameEnd)
      begin
         state_next.maintPending = state_reg.frameErr || (groupDone && violNow);
         state_next.maint = state_reg.maintPending;
         state_next.frameErr = 1'b0;
         if ((state_reg.frameErr || (groupDone && violNow)) && state_reg.errCnt != `TLDM_ERR_MAX)
            state_next.errCnt = state_reg.errCnt + 8'h01;
      end
      if (errCountRead)
         state_next.errCnt = 8'h00;
      if (!countingState(linkState))
         state_next.errCnt = 8'h00;
      if (txBitValid)
      begin
         // Self-synchronising scrambler: feedback of sent bits
         state_next.txOut = txBitIn ^ state_reg.scr[`TLDM_SCR_TAP - 5'd1]
            ^ state_reg.scr[22];
         state_next.scr = {state_reg.scr[21:0], state_next.txOut};
         state_next.txOutValid = 1'b1;
      end
      if (hostFrameStrobe)
      begin
         state_next.cmdLast = cmdIn;
         if (cmdIn == state_reg.cmdLast && cmdIn != state_reg.cmdOk)
         begin
            state_next.cmdOk = cmdIn;
            state_next.changed = 1'b1;
         end
         if (legalInd(indIn))
            state_next.ind = indIn;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         state_reg <= '0;
         state_reg.runSum <= 4'(`TLDM_SUM_RESET);
         state_reg.cmdOk <= `TLDM_CMD_DI;
         state_reg.cmdLast <= `TLDM_CMD_DI;
         state_reg.ind <= `TLDM_IND_DC;
      end
      else
         state_reg <= state_next;
   end

   // Decoded nibbles and violation flag buffered toward the frame side
   tldm_fifo #(
      .WIDTH(5),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .reset(reset),
      .inValid(groupDone),
      .inReady(fifoInReady),
      .inData({decodeGroup(groupFull), violNow}),
      .outValid(rxOutValid),
      .outReady(rxOutReady),
      .outData({rxOutData, codeViolation})
   );

   assign maintPositive = state_reg.maint;
   assign errCount = state_reg.errCnt;
   assign txBitOut = state_reg.txOut;
   assign txBitOutValid = state_reg.txOutValid;
   assign cmdValid = state_reg.cmdOk;
   assign cmdChanged = state_reg.changed;
   assign cmdTimingReq = state_reg.cmdOk == `TLDM_CMD_TIM;
   assign cmdFarDisable = state_reg.cmdOk == `TLDM_CMD_LTD;
   assign cmdSinglePulse = state_reg.cmdOk == `TLDM_CMD_SSP;
   assign cmdDataThrough = state_reg.cmdOk == `TLDM_CMD_DT;
   assign cmdActivationReq = state_reg.cmdOk == `TLDM_CMD_AR;
   assign cmdLayer1Up = state_reg.cmdOk == `TLDM_CMD_AI;
   assign cmdReset = state_reg.cmdOk == `TLDM_CMD_RES;
   assign cmdPowerDownAllowed = state_reg.cmdOk == `TLDM_CMD_DI;
   assign indOut = state_reg.ind;

   sat_hold_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg.errCnt == `TLDM_ERR_MAX && !errCountRead && countingState(linkState))
      |=> state_reg.errCnt == `TLDM_ERR_MAX)
      else $error("error count left saturation");
   read_clear_a: assert property (@(posedge clock) disable iff (reset)
      errCountRead |=> state_reg.errCnt == 8'h00)
      else $error("read did not clear count");
   idle_clear_a: assert property (@(posedge clock) disable iff (reset)
      !countingState(linkState) |=> state_reg.errCnt == 8'h00)
      else $error("count not cleared outside active states");
   frame_count_a: assert property (@(posedge clock) disable iff (reset)
      (rxFrameEnd && state_reg.frameErr && !errCountRead && countingState(linkState)
      && state_reg.errCnt != `TLDM_ERR_MAX)
      |=> state_reg.errCnt == $past(state_reg.errCnt) + 8'h01)
      else $error("block error not counted");
   maint_next_a: assert property (@(posedge clock) disable iff (reset)
      (rxFrameEnd && state_reg.maintPending) |=> maintPositive)
      else $error("maintenance symbol not raised");
   maint_pend_a: assert property (@(posedge clock) disable iff (reset)
      (rxFrameEnd && state_reg.frameErr) |=> state_reg.maintPending)
      else $error("bad frame not remembered");
   zero_viol_a: assert property (@(posedge clock) disable iff (reset)
      (groupDone && groupFull == 6'h00) |-> violNow)
      else $error("all-zero group not flagged");
   cmd_double_a: assert property (@(posedge clock) disable iff (reset)
      $changed(state_reg.cmdOk) |-> $past(hostFrameStrobe) && $past(cmdIn) == $past(state_reg.cmdLast))
      else $error("command accepted after one frame");
   ind_legal_a: assert property (@(posedge clock) disable iff (reset)
      legalInd(indOut))
      else $error("undefined indication driven");
   sum_range_a: assert property (@(posedge clock) disable iff (reset)
      (state_reg.symIdx == 2'd0) |-> (sumStart >= 4'(`TLDM_SUM_MIN) && sumStart <= 4'(`TLDM_SUM_MAX)))
      else $error("running sum not clamped");
endmodule // tldm_line_decode

/* File: tb/tldm_line_model.sv */
// Line terminal model that sends ternary groups toward the decoder
`timescale 1ns/1ps
module tldm_line_model (
   input wire logic clock,
   input wire logic rxSymReady,
   output logic rxSymValid,
   output logic [1:0] rxSym
);
   initial
   begin
      rxSymValid = 1'b0;
      rxSym = 2'h0;
   end

   // Digits: 0 zero, 1 plus, 2 minus; the leftmost digit goes out first
   task automatic sendGroup(input int idx);
      int d [3];
      d[0] = idx / 9;
      d[1] = (idx / 3) % 3;
      d[2] = idx % 3;
      for (int i = 0; i < 3; i++)
      begin
         @(negedge clock);
         rxSymValid = 1'b1;
         rxSym = (d[i] == 0) ? 2'h0 : ((d[i] == 1) ? 2'h1 : 2'h3);
         // Ready only moves on the rising edge, so judge it a half cycle before
         while (rxSymReady !== 1'b1)
         begin
            @(negedge clock);
         end
         @(posedge clock);
      end
      @(negedge clock);
      rxSymValid = 1'b0;
      // Released line shows the inverse so a stale symbol cannot pass
      rxSym = ~rxSym;
   endtask
endmodule // tldm_line_model

/* File: tb/tldm_line_decode_tb_top.sv */
// Self-checking bench for the ternary line decoder
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         errorCnt++; \
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp); \
      end \
   end
module tldm_line_decode_tb_top;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic rxSymValid, rxFrameEnd = 1'b0, rxOutReady = 1'b0, rxOutValid, rxSymReady;
   logic [1:0] rxSym;
   logic [3:0] rxOutData, cmdIn = 4'hF, indIn = 4'hF, cmdValid, indOut;
   logic codeViolation, maintPositive, errCountRead = 1'b0, cmdChanged;
   logic txBitValid = 1'b0, txBitIn = 1'b0, txBitOut, txBitOutValid;
   logic hostFrameStrobe = 1'b0, drainOn = 1'b0, sawMaint = 1'b0;
   logic [7:0] errCount, cmdDec;
   logic cmdTimingReq, cmdFarDisable, cmdSinglePulse, cmdDataThrough;
   logic cmdActivationReq, cmdLayer1Up, cmdReset, cmdPowerDownAllowed;
   tldm_pkg::tldm_link_state_t linkState = tldm_pkg::LINK_DEACTIVATED;
   logic [4:0] expQ [$];
   int errorCnt = 0, checks = 0, cycles = 0, chgCnt = 0, runSum = 1;
   // Nibble per group, index = 9*first + 3*second + third digit
   logic [3:0] decTab [27] = '{4'h0, 4'h3, 4'hF, 4'hD, 4'h5, 4'hE, 4'h0, 4'h1, 4'h8,
      4'h8, 4'h0, 4'hB, 4'hF, 4'hC, 4'hA, 4'h2, 4'h9, 4'hA,
      4'h5, 4'h7, 4'hD, 4'h4, 4'h6, 4'hC, 4'h3, 4'h6, 4'h9};

   assign cmdDec = {cmdTimingReq, cmdFarDisable, cmdSinglePulse, cmdDataThrough,
      cmdActivationReq, cmdLayer1Up, cmdReset, cmdPowerDownAllowed};

   tldm_line_model model (.clock(clock), .rxSymReady(rxSymReady), .rxSymValid(rxSymValid),
      .rxSym(rxSym));

   tldm_line_decode uut (.clock(clock), .reset(reset), .rxSymValid(rxSymValid),
      .rxSym(rxSym), .rxFrameEnd(rxFrameEnd), .rxOutReady(rxOutReady),
      .rxOutValid(rxOutValid), .rxOutData(rxOutData), .rxSymReady(rxSymReady),
      .codeViolation(codeViolation), .maintPositive(maintPositive), .linkState(linkState),
      .errCountRead(errCountRead), .errCount(errCount), .txBitValid(txBitValid),
      .txBitIn(txBitIn), .txBitOut(txBitOut), .txBitOutValid(txBitOutValid),
      .hostFrameStrobe(hostFrameStrobe), .cmdIn(cmdIn), .cmdValid(cmdValid),
      .cmdChanged(cmdChanged), .cmdTimingReq(cmdTimingReq), .cmdFarDisable(cmdFarDisable),
      .cmdSinglePulse(cmdSinglePulse), .cmdDataThrough(cmdDataThrough),
      .cmdActivationReq(cmdActivationReq), .cmdLayer1Up(cmdLayer1Up), .cmdReset(cmdReset),
      .cmdPowerDownAllowed(cmdPowerDownAllowed), .indIn(indIn), .indOut(indOut));

   initial
   begin
      forever #10 clock = ~clock;
   end

   task automatic testDone;
      if (errorCnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         errorCnt++;
         testDone();
      end
   end

   // Consumer with a stalling ready; a transfer seen here lands at the next edge
   always @(negedge clock)
   begin
      rxOutReady = drainOn && (cycles % 3 != 0);
      if (rxOutValid === 1'b1 && rxOutReady === 1'b1)
      begin
         if (expQ.size() == 0)
            `CHK(1'b0, 1'b1)
         else
            `CHK({rxOutData, codeViolation}, expQ.pop_front())
      end
      if (maintPositive === 1'b1)
         sawMaint = 1'b1;
      if (cmdChanged === 1'b1)
         chgCnt++;
   end

   // Tracks the running sum the way the line monitor should
   task automatic sendTracked(input int idx);
      int d;
      logic nz;
      nz = 1'b0;
      if (runSum > 4)
         runSum = 4;
      else if (runSum <= 0)
         runSum = 1;
      for (int i = 0; i < 3; i++)
      begin
         d = (i == 0) ? idx / 9 : ((i == 1) ? (idx / 3) % 3 : idx % 3);
         runSum += (d == 1) ? 1 : ((d == 2) ? -1 : 0);
         nz |= (d != 0);
      end
      expQ.push_back({decTab[idx], runSum < 1 || runSum > 4 || !nz});
      model.sendGroup(idx);
   endtask

   task automatic scenTx;
      logic [22:0] hist;
      logic y;
      hist = '0;
      for (int i = 0; i < 49; i++)
      begin
         @(negedge clock);
         if (i > 0)
         begin
            `CHK(txBitOutValid, 1'b1)
            `CHK(txBitOut, y)
         end
         txBitValid = (i < 48);
         txBitIn = ((i * 7) % 5) < 2;
         y = txBitIn ^ hist[17] ^ hist[22];
         hist = {hist[21:0], y};
      end
   endtask

   task automatic strobe(input logic [3:0] c);
      @(negedge clock);
      hostFrameStrobe = 1'b1;
      cmdIn = (c == 4'hA) ? cmdValid : c;
      indIn = c;
      @(negedge clock);
      hostFrameStrobe = 1'b0;
      repeat (2) @(negedge clock);
   endtask

   task automatic scenCmd;
      logic [3:0] expCmd, expInd, c;
      int chg;
      expCmd = 4'hF;
      expInd = 4'hF;
      for (int k = 0; k < 16; k++)
      begin
         c = k[3:0];
         chg = chgCnt;
         strobe(c);
         `CHK(cmdValid, expCmd)
         if (c inside {4'h0, 4'h4, 4'h8, 4'hA, 4'hC, 4'hE, 4'hF})
            expInd = c;
         `CHK(indOut, expInd)
         repeat (3) strobe(c);
         `CHK(chgCnt - chg, (c != expCmd && c != 4'hA) ? 1 : 0)
         if (c != 4'hA)
            expCmd = c;
         `CHK(cmdValid, expCmd)
         `CHK(cmdDec, {expCmd == 4'h0, expCmd == 4'h3, expCmd == 4'h5, expCmd == 4'h6,
            expCmd == 4'h8, expCmd == 4'hC, expCmd == 4'hD, expCmd == 4'hF})
      end
   endtask

   task automatic scenDecode;
      for (int i = 0; i < 8; i++)
         sendTracked(i);
      repeat (2) @(negedge clock);
      `CHK(rxSymReady, 1'b0)
      drainOn = 1'b1;
      for (int i = 8; i < 27; i++)
         sendTracked(i);
      for (int i = 0; i < 100 && expQ.size() > 0; i++)
         @(negedge clock);
      `CHK(expQ.size(), 0)
   endtask

   task automatic frameEnd(input logic bad);
      if (bad)
         sendTracked(0);
      repeat (2) @(negedge clock);
      rxFrameEnd = 1'b1;
      @(negedge clock);
      rxFrameEnd = 1'b0;
      @(negedge clock);
   endtask

   task automatic scenErr;
      tldm_pkg::tldm_link_state_t act [4] = '{tldm_pkg::LINK_SYNCHRONIZING,
         tldm_pkg::LINK_WAIT_INFO, tldm_pkg::LINK_FOUR_HIGH, tldm_pkg::LINK_TRANSPARENT};
      frameEnd(1'b1);
      `CHK(errCount, 8'h00)
      for (int k = 0; k < 4; k++)
      begin
         linkState = act[k];
         frameEnd(1'b1);
         `CHK(errCount, 8'(k + 1))
      end
      repeat (260) frameEnd(1'b1);
      `CHK(errCount, 8'hFF)
      `CHK(sawMaint, 1'b1)
      repeat (2) frameEnd(1'b0);
      sawMaint = 1'b0;
      repeat (2) frameEnd(1'b0);
      `CHK(sawMaint, 1'b0)
      `CHK(errCount, 8'hFF)
      errCountRead = 1'b1;
      `CHK(errCount, 8'hFF)
      @(negedge clock);
      errCountRead = 1'b0;
      `CHK(errCount, 8'h00)
      linkState = tldm_pkg::LINK_OTHER;
      frameEnd(1'b1);
      `CHK(errCount, 8'h00)
   endtask

   initial
   begin
      repeat (2) @(negedge clock);
      reset = 1'b0;
      `CHK({cmdValid, indOut, errCount, rxSymReady}, {4'hF, 4'hF, 8'h00, 1'b1})
      scenTx();
      scenCmd();
      scenDecode();
      scenErr();
      testDone();
   end
endmodule // tldm_line_decode_tb_top
